// File: hw/blanking_consts.vh
// constants shared by the fixed beam blanking evaluator and its mask checker
`ifndef BLANKING_CONSTS_VH
`define BLANKING_CONSTS_VH

// beam vector geometry
`define BEAM_CNT     16
`define BEAM_MSB     15
`define BEAM_ZERO    16'h0000

// synchronization beams and their neighbours, one at each end of the grid
`define SYNC_LO      0
`define SYNC_LO_NB   1
`define SYNC_HI      15
`define SYNC_HI_NB   14

// blanking modes
`define MODE_OFF     2'h0
`define MODE_FIX     2'h1
`define MODE_EDGE    2'h2
`define MODE_W       2

// edge tolerance figures, in beams
`define EDGE_TOL     1
`define MIN_OBJ      2
`define MIN_GAP      1

// reset values
`define MASK_RST     16'h0000
`define MODE_RST     2'h0

// controller states, one-hot
`define ST_W         3
`define ST_RUN       3'h1
`define ST_TEACH     3'h2
`define ST_FAULT     3'h4

`endif

// File: hw/hidden_area_check.v
// hidden-area configuration checker, purely combinational
`include "blanking_consts.vh"

module hidden_area_check (
  input  wire [`MODE_W-1:0]   mode,
  input  wire [`BEAM_MSB:0]   mask,
  output reg                  mask_ok
);

  ////////////////////////////////////////////////////////////////////////////
  reg [`BEAM_CNT+1:0] maskx;
  reg                 sync_lo_free;
  reg                 sync_hi_free;
  integer             i;
  integer             s;
  integer             len;
  reg                 run;
  integer             j;

  always @* begin
    maskx        = {1'b0, mask, 1'b0};
    sync_lo_free = ~mask[`SYNC_LO] & ~mask[`SYNC_LO_NB];
    sync_hi_free = ~mask[`SYNC_HI] & ~mask[`SYNC_HI_NB];
    mask_ok      = 1'b1;
    s            = 0;
    len          = 0;
    run          = 1'b0;
    if (!sync_lo_free && !sync_hi_free) begin
      mask_ok = 1'b0;
    end
    if (mode != `MODE_FIX && mode != `MODE_EDGE && mode != `MODE_OFF) begin
      mask_ok = 1'b0;
    end
    // areas are maximal runs of set bits, so a gap of one clear beam always
    // separates them and no count limit applies
    for (i = 0; i < `BEAM_CNT; i = i + 1) begin
      if (maskx[i+1] && !maskx[i]) begin
        s   = i;
        len = 0;
        run = 1'b1;
        for (j = 0; j < `BEAM_CNT; j = j + 1) begin
          if (j >= s && run && mask[j]) begin
            len = len + 1;
          end else if (j >= s) begin
            run = 1'b0;
          end
        end
        if (mode == `MODE_EDGE && len < `MIN_OBJ) begin
          mask_ok = 1'b0;
        end
      end
    end
  end

endmodule

// File: hw/fixed_beam_blanking_evaluator.v
// fixed beam blanking evaluator with optional one-beam edge tolerance
// What this block does
// - hidden beams excluded from penetration evaluation
// - covered unhidden beam switches outputs off
// - clear beam inside hidden area means error
// - reject masks hiding both sync beam pairs
// - hidden areas separated by one clear beam
// - no limit on number of hidden areas
// - mask loaded by teach-in or link write
// - fixed mode needs exact match to mask
// - fixed shift/shrink errors, growth is penetration
// - merged objects cause error state
// - edge mode tolerates one-beam edge deviation
// - edge mode objects cover two beams minimum
// - edge mode allows only one deviation
// - edge gap grows with moving objects
// - edge displacement over one beam errors
`include "blanking_consts.vh"

module fixed_beam_blanking_evaluator (
  input  wire                 clk_sys,
  input  wire                 rst_b,
  input  wire                 scan_valid,
  input  wire [`BEAM_MSB:0]   scan_beams,
  input  wire                 cfg_wr,
  input  wire [`MODE_W-1:0]   cfg_mode,
  input  wire [`BEAM_MSB:0]   cfg_mask,
  input  wire                 teach_req,
  input  wire                 err_clear,
  output wire                 safety_switching_output,
  output wire                 field_penetrated,
  output wire                 error_state,
  output wire                 teach_busy,
  output wire                 cfg_accept,
  output wire                 cfg_reject,
  output wire [`BEAM_MSB:0]   hidden_mask,
  output wire [`MODE_W-1:0]   blank_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  reg [`ST_W-1:0]     state_q;
  reg [`ST_W-1:0]     state_d;
  reg [`BEAM_MSB:0]   mask_q;
  reg [`BEAM_MSB:0]   mask_d;
  reg [`MODE_W-1:0]   mode_q;
  reg [`MODE_W-1:0]   mode_d;
  reg                 sso_q;
  reg                 sso_d;
  reg                 pen_q;
  reg                 pen_d;
  reg                 acc_q;
  reg                 acc_d;
  reg                 rej_q;
  reg                 rej_d;
  reg                 last_err_q;
  reg                 last_err_d;

  wire                link_ok;
  wire                teach_ok;

  ////////////////////////////////////////////////////////////////////////////
  // configuration checks: one for link writes, one for teach captures
  hidden_area_check link_chk (
    .mode    (cfg_mode),
    .mask    (cfg_mask),
    .mask_ok (link_ok)
  );

  hidden_area_check teach_chk (
    .mode    (mode_q),
    .mask    (scan_beams),
    .mask_ok (teach_ok)
  );

  ////////////////////////////////////////////////////////////////////////////
  // scan evaluation against the mask
  reg [`BEAM_CNT+3:0] covx;
  reg [`BEAM_CNT:0]   emaskx;
  reg [`BEAM_MSB:0]   emask;
  reg [`BEAM_MSB:0]   claim;
  reg                 ev_err;
  reg                 ev_pen;
  reg                 edge_md;
  reg                 run;
  reg                 bridged;
  reg                 lost;
  reg                 have_prev;
  integer             i;
  integer             j;
  integer             k;
  integer             s;
  integer             e;
  integer             ds;
  integer             de;
  integer             rs;
  integer             re;
  integer             pe;
  integer             pre;
  integer             mov;
  integer             pmov;

  always @* begin
    covx      = {2'b00, scan_beams, 2'b00};
    edge_md   = (mode_q == `MODE_EDGE);
    if (mode_q == `MODE_FIX || mode_q == `MODE_EDGE) begin
      emask = mask_q;
    end else begin
      emask = `BEAM_ZERO;
    end
    emaskx    = {emask, 1'b0};
    claim     = `BEAM_ZERO;
    ev_err    = 1'b0;
    ev_pen    = 1'b0;
    run       = 1'b0;
    bridged   = 1'b0;
    lost      = 1'b0;
    have_prev = 1'b0;
    s         = 0;
    e         = 0;
    ds        = 0;
    de        = 0;
    rs        = 0;
    re        = 0;
    pe        = 0;
    pre       = 0;
    mov       = 0;
    pmov      = 0;
    for (i = 0; i < `BEAM_CNT; i = i + 1) begin
      if (emaskx[i+1] && !emaskx[i]) begin
        // bounds of this hidden area
        s   = i;
        e   = i;
        run = 1'b1;
        for (j = 0; j < `BEAM_CNT; j = j + 1) begin
          if (j >= s && run && emask[j]) begin
            e = j;
          end else if (j >= s) begin
            run = 1'b0;
          end
        end
        // edge offsets of the covered group; fixed mode allows none
        ds   = 0;
        de   = 0;
        lost = 1'b0;
        if (edge_md) begin
          if (covx[s+1]) begin
            ds = -`EDGE_TOL;
          end else if (covx[s+2]) begin
            ds = 0;
          end else if (covx[s+3]) begin
            ds = `EDGE_TOL;
          end else begin
            lost = 1'b1;
          end
          if (covx[e+3]) begin
            de = `EDGE_TOL;
          end else if (covx[e+2]) begin
            de = 0;
          end else if (covx[e+1]) begin
            de = -`EDGE_TOL;
          end else begin
            lost = 1'b1;
          end
        end
        rs = s + ds;
        re = e + de;
        if (lost) begin
          ev_err = 1'b1;
        end
        // growth at both edges exceeds the tolerance and opens the field
        if (ds == -`EDGE_TOL && de == `EDGE_TOL) begin
          ev_pen = 1'b1;
        end
        // shrinking at both edges is two deviations, not one
        if (ds == `EDGE_TOL && de == -`EDGE_TOL) begin
          ev_err = 1'b1;
        end
        // every beam of the accepted group must be covered
        for (k = 0; k < `BEAM_CNT; k = k + 1) begin
          if (k >= rs && k <= re) begin
            claim[k] = 1'b1;
            if (!scan_beams[k]) begin
              ev_err = 1'b1;
            end
          end
        end
        if (edge_md && (re - rs + 1) < `MIN_OBJ) begin
          ev_err = 1'b1;
        end
        mov = ((ds != 0) || (de != 0)) ? 1 : 0;
        if (have_prev) begin
          bridged = 1'b1;
          for (k = 0; k < `BEAM_CNT; k = k + 1) begin
            if (k > pe && k < s && !scan_beams[k]) begin
              bridged = 1'b0;
            end
          end
          if (bridged) begin
            ev_err = 1'b1;
          end
          if (edge_md && (rs - pre - 1) < (`MIN_GAP + mov + pmov)) begin
            ev_err = 1'b1;
          end
        end
        have_prev = 1'b1;
        pe        = e;
        pre       = re;
        pmov      = mov;
      end
    end
    // any covered beam outside every accepted group is a penetration
    if (|(scan_beams & ~claim)) begin
      ev_pen = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // controller
  always @* begin
    state_d    = state_q;
    mask_d     = mask_q;
    mode_d     = mode_q;
    sso_d      = sso_q;
    pen_d      = pen_q;
    acc_d      = 1'b0;
    rej_d      = 1'b0;
    last_err_d = last_err_q;
    case (state_q)
      `ST_RUN: begin
        if (cfg_wr) begin
          // outputs drop on any reconfiguration until a scan has been judged
          sso_d = 1'b0;
          pen_d = 1'b0;
          if (link_ok) begin
            mask_d = cfg_mask;
            mode_d = cfg_mode;
            acc_d  = 1'b1;
          end else begin
            rej_d  = 1'b1;
          end
        end else if (teach_req) begin
          sso_d   = 1'b0;
          pen_d   = 1'b0;
          state_d = `ST_TEACH;
        end else if (scan_valid) begin
          last_err_d = ev_err;
          pen_d      = ev_pen & ~ev_err;
          sso_d      = ~ev_pen & ~ev_err;
          if (ev_err) begin
            state_d = `ST_FAULT;
          end
        end
      end
      `ST_TEACH: begin
        if (cfg_wr) begin
          rej_d = 1'b1;
        end else if (scan_valid) begin
          state_d = `ST_RUN;
          if (teach_ok) begin
            mask_d = scan_beams;
            acc_d  = 1'b1;
          end else begin
            rej_d  = 1'b1;
          end
        end
      end
      `ST_FAULT: begin
        sso_d = 1'b0;
        pen_d = 1'b0;
        if (cfg_wr) begin
          if (link_ok) begin
            mask_d = cfg_mask;
            mode_d = cfg_mode;
            acc_d  = 1'b1;
          end else begin
            rej_d  = 1'b1;
          end
        end else if (scan_valid) begin
          last_err_d = ev_err;
        end else if (err_clear && !last_err_q) begin
          // leaving the fault needs a clean scan first; the outputs come back
          // only after the next judged scan
          state_d = `ST_RUN;
        end
      end
      default: begin
        state_d = `ST_FAULT;
        sso_d   = 1'b0;
        pen_d   = 1'b0;
      end
    endcase
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q    <= `ST_RUN;
      mask_q     <= `MASK_RST;
      mode_q     <= `MODE_RST;
      sso_q      <= 1'b0;
      pen_q      <= 1'b0;
      acc_q      <= 1'b0;
      rej_q      <= 1'b0;
      last_err_q <= 1'b1;
    end else begin
      state_q    <= state_d;
      mask_q     <= mask_d;
      mode_q     <= mode_d;
      sso_q      <= sso_d;
      pen_q      <= pen_d;
      acc_q      <= acc_d;
      rej_q      <= rej_d;
      last_err_q <= last_err_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign safety_switching_output = sso_q;
  assign field_penetrated        = pen_q;
  assign error_state             = (state_q == `ST_FAULT);
  assign teach_busy              = (state_q == `ST_TEACH);
  assign cfg_accept              = acc_q;
  assign cfg_reject              = rej_q;
  assign hidden_mask             = mask_q;
  assign blank_mode              = mode_q;

endmodule

// File: tb/blanking_properties.sv
// port-level checks for the fixed beam blanking evaluator
`include "blanking_consts.vh"
module blanking_properties (
  input wire                 clk_sys,
  input wire                 rst_b,
  input wire                 scan_valid,
  input wire [`BEAM_MSB:0]   scan_beams,
  input wire                 cfg_wr,
  input wire [`MODE_W-1:0]   cfg_mode,
  input wire [`BEAM_MSB:0]   cfg_mask,
  input wire                 teach_req,
  input wire                 err_clear,
  input wire                 safety_switching_output,
  input wire                 field_penetrated,
  input wire                 error_state,
  input wire                 teach_busy,
  input wire                 cfg_accept,
  input wire                 cfg_reject,
  input wire [`BEAM_MSB:0]   hidden_mask,
  input wire [`MODE_W-1:0]   blank_mode
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // a scan that is judged in run, not swallowed by a write or teach
  wire run_scan = scan_valid && !cfg_wr && !teach_req && !teach_busy && !error_state;
  //////////////////////////////////////////////////////////////////////////////
  chk_pen_outputs_off: assert property (
    field_penetrated |-> !safety_switching_output) else $error("penetration with outputs on");
  chk_error_outputs_off: assert property (
    error_state |-> !safety_switching_output) else $error("error with outputs on");
  chk_teach_outputs_off: assert property (
    teach_busy |-> !safety_switching_output) else $error("teach with outputs on");
  chk_off_mode_pen: assert property (
    blank_mode == `MODE_OFF && scan_valid && |scan_beams |=> !safety_switching_output)
    else $error("covered beam left outputs on");
  chk_exact_match_on: assert property (
    run_scan && blank_mode == `MODE_FIX && scan_beams == hidden_mask |=> safety_switching_output)
    else $error("exact match did not switch on");
  chk_sync_pair_reject: assert property (
    cfg_wr && |cfg_mask[`SYNC_LO_NB:`SYNC_LO] && |cfg_mask[`SYNC_HI:`SYNC_HI_NB]
    |=> cfg_reject && !cfg_accept) else $error("sync beams hidden but accepted");
  chk_mask_load: assert property (
    cfg_wr && !teach_busy ##1 cfg_accept |-> hidden_mask == $past(cfg_mask)
    && blank_mode == $past(cfg_mode)) else $error("accepted write not loaded");
  chk_answer_exclusive: assert property (
    !(cfg_accept && cfg_reject)) else $error("accept and reject together");
  chk_on_after_scan: assert property (
    $rose(safety_switching_output) |-> $past(scan_valid)) else $error("outputs on without scan");
  cover property (cfg_accept);
  cover property ($rose(error_state));
  cover property ($rose(teach_busy));
endmodule

bind fixed_beam_blanking_evaluator blanking_properties i_blanking_properties (
  .clk_sys(clk_sys), .rst_b(rst_b), .scan_valid(scan_valid), .scan_beams(scan_beams),
  .cfg_wr(cfg_wr), .cfg_mode(cfg_mode), .cfg_mask(cfg_mask), .teach_req(teach_req),
  .err_clear(err_clear), .safety_switching_output(safety_switching_output),
  .field_penetrated(field_penetrated), .error_state(error_state), .teach_busy(teach_busy),
  .cfg_accept(cfg_accept), .cfg_reject(cfg_reject), .hidden_mask(hidden_mask),
  .blank_mode(blank_mode));

// File: tb/beam_front_model.sv
// beam scanning front end model: one whole vector per requested scan
module beam_front_model (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        scan_req,
  input  wire logic [15:0] scan_vec,
  output logic             scan_valid,
  output logic [15:0]      scan_beams
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] last_q;
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) last_q <= 16'h0000;
    else if (scan_req) last_q <= scan_vec;
  end
  assign scan_valid = scan_req;
  // vector not held between scans, so a stray sample never sees the last pattern
  assign scan_beams = scan_req ? scan_vec : ~last_q;
endmodule

// File: tb/fixed_beam_blanking_evaluator_tb.sv
// self-checking bench for the fixed beam blanking evaluator
module fixed_beam_blanking_evaluator_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys, rst_b, scan_req, cfg_wr, teach_req, err_clear;
  logic [15:0] scan_vec, cfg_mask, cur_mask;
  logic [1:0]  cfg_mode, cur_mode;
  wire         scan_valid, sso, pen, err, busy, acc, rej;
  wire [15:0]  scan_beams, hmask;
  wire [1:0]   bmode;
  int          fails, samples_checked, i;
  // top two bits: expected verdict, 0 on, 1 penetration, 2 error
  logic [17:0] fix_t[8] = '{18'h200E0, 18'h20380, 18'h20180, 18'h200C0,
                            18'h101E0, 18'h103C0, 18'h20080, 18'h103E0};
  logic [17:0] edg_t[9] = '{18'h000E0, 18'h00380, 18'h00180, 18'h000C0, 18'h001E0,
                            18'h003C0, 18'h20300, 18'h20080, 18'h103E0};
  beam_front_model i_beam_front_model (.clk_sys(clk_sys), .rst_b(rst_b), .scan_req(scan_req),
    .scan_vec(scan_vec), .scan_valid(scan_valid), .scan_beams(scan_beams));
  fixed_beam_blanking_evaluator i_fixed_beam_blanking_evaluator (.clk_sys(clk_sys),
    .rst_b(rst_b), .scan_valid(scan_valid), .scan_beams(scan_beams), .cfg_wr(cfg_wr),
    .cfg_mode(cfg_mode), .cfg_mask(cfg_mask), .teach_req(teach_req), .err_clear(err_clear),
    .safety_switching_output(sso), .field_penetrated(pen), .error_state(err),
    .teach_busy(busy), .cfg_accept(acc), .cfg_reject(rej), .hidden_mask(hmask),
    .blank_mode(bmode));
  //////////////////////////////////////////////////////////////////////////////
  task complete_run;
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // wide enough for status bits packed above the whole mask
  task cmp(input logic [19:0] got, input logic [19:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task pulse(input int which);
    @(posedge clk_sys);
    #1;
    if (which == 0) begin
      scan_req = 1;
    end else if (which == 1) begin
      teach_req = 1;
    end else begin
      err_clear = 1;
    end
    @(posedge clk_sys);
    #1 {scan_req, teach_req, err_clear} = 3'h0;
  endtask
  task scan(input logic [15:0] v);
    scan_vec = v;
    pulse(0);
  endtask
  task cfg(input logic [1:0] m, input logic [15:0] k, input logic ok);
    @(posedge clk_sys);
    #1 {cfg_wr, cfg_mode, cfg_mask} = {1'b1, m, k};
    @(posedge clk_sys);
    #1 cfg_wr = 0;
    if (ok) begin
      cur_mask = k;
      cur_mode = m;
    end
    cmp({acc, rej}, ok ? 2'h2 : 2'h1);
    cmp({bmode, hmask}, {cur_mode, cur_mask});
  endtask
  // error lockout leaves only after a clean scan and a clear request
  task judge(input logic [17:0] t);
    scan(t[15:0]);
    cmp({sso, pen, err}, t[17] ? 3'h1 : t[16] ? 3'h2 : 3'h4);
    if (t[17]) begin
      pulse(2);
      cmp(err, 1);
      scan(cur_mask);
      pulse(2);
      cmp(err, 0);
      scan(cur_mask);
      cmp(sso, 1);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task t_off_mode;
    cfg(2'h0, 16'h0000, 1);
    judge(18'h00000);
    judge(18'h10010);
  endtask
  task t_fixed_one;
    cfg(2'h1, 16'h01C0, 1);
    judge({2'h0, 16'h01C0});
    for (i = 0; i < 8; i++) judge(fix_t[i]);
  endtask
  task t_fixed_two;
    cfg(2'h1, 16'h06C0, 1);
    judge(18'h203C0);
    judge(18'h20360);
    judge(18'h10EC0);
  endtask
  task t_config;
    cfg(2'h1, 16'h2AA8, 1);
    judge(18'h02AA8);
    cfg(2'h1, 16'hC003, 0);
    cfg(2'h3, 16'h0000, 0);
    cfg(2'h2, 16'h0100, 0);
    cfg(2'h1, 16'h0003, 1);
  endtask
  task t_edge;
    cfg(2'h2, 16'h01C0, 1);
    for (i = 0; i < 9; i++) judge(edg_t[i]);
    cfg(2'h2, 16'h06C0, 1);
    judge(18'h00660);
    judge(18'h00C60);
    judge(18'h20D80);
    judge(18'h203C0);
  endtask
  task t_teach;
    pulse(1);
    cmp({busy, sso}, 2'h2);
    scan(16'h0F00);
    cmp({busy, acc, rej, hmask}, {3'h2, 16'h0F00});
    cur_mask = 16'h0F00;
    judge(18'h00F00);
    pulse(1);
    cfg(2'h1, 16'h0000, 0);
    cmp(busy, 1);
    scan(16'hC003);
    cmp({acc, rej, hmask}, {2'h1, 16'h0F00});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    #20us;
    fails++;
    $display("FAIL %0t watchdog expired", $time);
    complete_run;
  end
  initial begin
    {rst_b, scan_req, cfg_wr, teach_req, err_clear} = 5'h0;
    {scan_vec, cfg_mask, cur_mask, cfg_mode, cur_mode} = 52'h0;
    fails = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk_sys);
    #1 rst_b = 1;
    t_off_mode;
    t_fixed_one;
    t_fixed_two;
    t_config;
    t_edge;
    cfg(2'h1, 16'h0000, 1);
    t_teach;
    complete_run;
  end
endmodule
